// >>> include/adc_timing_defines.vh
// constants for the converter timing control block
`ifndef ADC_TIMING_DEFINES_VH
`define ADC_TIMING_DEFINES_VH

// clock select codes
`define CLKSEL_DIV4 2'h0
`define CLKSEL_DIV2 2'h1
`define CLKSEL_DIV16 2'h2
`define CLKSEL_DIV8 2'h3
// divider terminal counts (divide-by minus one)
`define DIV4_LAST 4'h3
`define DIV2_LAST 4'h1
`define DIV16_LAST 4'hf
`define DIV8_LAST 4'h7
// divider count held while stopped; tick is registered, so this lands the first tick on time
`define DIV_PRELOAD 4'h1
// sample lengths in basic clock periods
`define SAMPLE_8 7'h08
`define SAMPLE_16 7'h10
`define SAMPLE_32 7'h20
`define SAMPLE_64 7'h40
// result determination length in basic clock periods
`define SAR_STEPS 7'h28
// trailing cpu clock periods for loading the result
`define LOAD_CYCLES 2'h2
// calibration length in basic clock periods
`define CAL_PERIODS 12'hd00
// result codes at the rails
`define RESULT_ZERO 10'h000
`define RESULT_FULL 10'h3ff
// control word field positions
`define CW_CLKSEL_HI 15
`define CW_CLKSEL_LO 14
`define CW_SAMPLE_HI 13
`define CW_SAMPLE_LO 12

`endif

// >>> hdl/basic_clock_gen.v
// basic converter clock tick generator with selectable divider
`timescale 1ns/1ps
`include "adc_timing_defines.vh"

module basic_clock_gen (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire run,
   input wire [1:0] clkSel,
   // tick output
   output reg tick
);

   reg [3:0] count_reg;
   reg [3:0] last;

   // --------------------------------
   // divider terminal count
   // --------------------------------
   always @* begin
      case (clkSel)
         `CLKSEL_DIV4: last = `DIV4_LAST;
         `CLKSEL_DIV2: last = `DIV2_LAST;
         `CLKSEL_DIV16: last = `DIV16_LAST;
         `CLKSEL_DIV8: last = `DIV8_LAST;
         default: last = `DIV4_LAST;
      endcase
   end

   // restarts on run low so each conversion starts phase aligned
   // preload of one keeps a phase exactly a whole number of basic periods
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 4'h0;
         tick <= 1'b0;
      end else if (!run) begin
         count_reg <= `DIV_PRELOAD;
         tick <= 1'b0;
      end else if (count_reg == last) begin
         count_reg <= 4'h0;
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 4'h1;
         tick <= 1'b0;
      end
   end

endmodule // basic_clock_gen

// >>> hdl/adc_conversion_timing.v
// converter timing control: sample, approximation, load and calibration
`timescale 1ns/1ps
`include "adc_timing_defines.vh"


module adc_conversion_timing (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire [15:0] controlWord,
   input wire startConv,
   // analog front end comparator results
   input wire [9:0] analogCode,
   input wire belowGround,
   input wire aboveRef,
   // status and result
   output reg busy,
   output reg sampling,
   output reg holdSample,
   output reg calibrating,
   output reg resultValid,
   output reg [9:0] result
);

   localparam IDLE = 3'h0;
   localparam SAMPLE = 3'h1;
   localparam CONVERT = 3'h2;
   localparam LOAD = 3'h3;
   localparam CALIB = 3'h4;

   reg [2:0] state_reg, state_next;
   reg [1:0] clkSel_reg;
   reg [1:0] sampleSel_reg;
   reg [6:0] phaseCnt_reg;
   reg [1:0] loadCnt_reg;
   reg [11:0] calCnt_reg;
   reg calDone_reg;
   reg [9:0] held_reg;
   reg heldLow_reg, heldHigh_reg;
   reg s1Start_reg, s2Start_reg;
   reg [9:0] s1Code_reg, s2Code_reg;
   reg s1Low_reg, s2Low_reg, s1High_reg, s2High_reg;
   wire tick;
   wire runDiv;

   // --------------------------------
   // sample length decode
   // --------------------------------
   function [6:0] sampleLen;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: sampleLen = `SAMPLE_8;
            2'h1: sampleLen = `SAMPLE_16;
            2'h2: sampleLen = `SAMPLE_32;
            2'h3: sampleLen = `SAMPLE_64;
            default: sampleLen = `SAMPLE_8;
         endcase
      end
   endfunction

   // --------------------------------
   // input synchronisers
   // --------------------------------
   // analog side is asynchronous to clk, two stages before use
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1Start_reg <= 1'b0;
         s2Start_reg <= 1'b0;
         s1Code_reg <= 10'h000;
         s2Code_reg <= 10'h000;
         s1Low_reg <= 1'b0;
         s2Low_reg <= 1'b0;
         s1High_reg <= 1'b0;
         s2High_reg <= 1'b0;
      end else begin
         s1Start_reg <= startConv;
         s2Start_reg <= s1Start_reg;
         s1Code_reg <= analogCode;
         s2Code_reg <= s1Code_reg;
         s1Low_reg <= belowGround;
         s2Low_reg <= s1Low_reg;
         s1High_reg <= aboveRef;
         s2High_reg <= s1High_reg;
      end
   end

   // --------------------------------
   // basic clock
   // --------------------------------
   // divider runs in calibration, sampling and approximation only
   assign runDiv = (state_reg == SAMPLE) || (state_reg == CONVERT) || (state_reg == CALIB);

   basic_clock_gen basic_clock_gen_inst (
      .clk(clk),
      .rst_n(rst_n),
      .run(runDiv),
      .clkSel(clkSel_reg),
      .tick(tick)
   );

   // --------------------------------
   // sequencer
   // --------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         IDLE: begin
            if (s2Start_reg) begin
               state_next = SAMPLE;
            end else if (!calDone_reg) begin
               state_next = CALIB;
            end
         end
         CALIB: begin
            // start pre-empts calibration; its counter pauses meanwhile
            if (s2Start_reg) begin
               state_next = IDLE;
            end else if (tick && calCnt_reg == `CAL_PERIODS - 12'h001) begin
               state_next = IDLE;
            end
         end
         SAMPLE: begin
            if (tick && phaseCnt_reg == sampleLen(sampleSel_reg) - 7'h01) begin
               state_next = CONVERT;
            end
         end
         CONVERT: begin
            if (tick && phaseCnt_reg == `SAR_STEPS - 7'h01) begin
               state_next = LOAD;
            end
         end
         LOAD: begin
            if (loadCnt_reg == `LOAD_CYCLES - 2'h1) begin
               state_next = IDLE;
            end
         end
         default: state_next = IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= IDLE;
         clkSel_reg <= `CLKSEL_DIV4;
         sampleSel_reg <= 2'h0;
         phaseCnt_reg <= 7'h00;
         loadCnt_reg <= 2'h0;
         calCnt_reg <= 12'h000;
         calDone_reg <= 1'b0;
         held_reg <= `RESULT_ZERO;
         heldLow_reg <= 1'b0;
         heldHigh_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // settings latched only when idle or calibrating, frozen while converting
         if (state_reg == IDLE || state_reg == CALIB) begin
            clkSel_reg <= controlWord[`CW_CLKSEL_HI:`CW_CLKSEL_LO];
            sampleSel_reg <= controlWord[`CW_SAMPLE_HI:`CW_SAMPLE_LO];
         end
         if (state_next != state_reg) begin
            phaseCnt_reg <= 7'h00;
         end else if (tick) begin
            phaseCnt_reg <= phaseCnt_reg + 7'h01;
         end
         if (state_reg == LOAD) begin
            loadCnt_reg <= loadCnt_reg + 2'h1;
         end else begin
            loadCnt_reg <= 2'h0;
         end
         if (state_reg == CALIB && tick) begin
            calCnt_reg <= calCnt_reg + 12'h001;
            if (calCnt_reg == `CAL_PERIODS - 12'h001) begin
               calDone_reg <= 1'b1;
            end
         end
         // track during sampling, freeze afterwards
         if (state_reg == SAMPLE) begin
            held_reg <= s2Code_reg;
            heldLow_reg <= s2Low_reg;
            heldHigh_reg <= s2High_reg;
         end
      end
   end

   // --------------------------------
   // outputs
   // --------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         sampling <= 1'b0;
         holdSample <= 1'b0;
         calibrating <= 1'b1;
         resultValid <= 1'b0;
         result <= `RESULT_ZERO;
      end else begin
         busy <= (state_next == SAMPLE) || (state_next == CONVERT) || (state_next == LOAD);
         sampling <= (state_next == SAMPLE);
         holdSample <= (state_next == CONVERT) || (state_next == LOAD);
         calibrating <= !calDone_reg && !(state_reg == CALIB && state_next == IDLE && !s2Start_reg);
         resultValid <= 1'b0;
         if (state_reg == LOAD && state_next == IDLE) begin
            resultValid <= 1'b1;
            if (heldLow_reg) begin
               result <= `RESULT_ZERO;
            end else if (heldHigh_reg) begin
               result <= `RESULT_FULL;
            end else begin
               result <= held_reg;
            end
         end
      end
   end

endmodule // adc_conversion_timing

// >>> sim/adc_conversion_timing_assertions.sv
// assertion checker for converter timing control
`timescale 1ns/1ps
module adc_conversion_timing_checker (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // watched ports
   input wire [15:0] controlWord,
   input wire busy,
   input wire sampling,
   input wire holdSample,
   input wire calibrating,
   input wire resultValid,
   input wire [9:0] result
);
   // ----
   // helper logic
   // ----
   reg [15:0] cwReg;
   reg [10:0] sampCnt;
   reg [10:0] div;
   wire [10:0] sampLen;
   always @* begin
      case (cwReg[15:14])
         2'h0: div = 11'h004;
         2'h1: div = 11'h002;
         2'h2: div = 11'h010;
         default: div = 11'h008;
      endcase
   end
   assign sampLen = div * (11'h008 << cwReg[13:12]);
   // settings only tracked while not busy, as the block freezes them too
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cwReg <= 16'h0000;
         sampCnt <= 11'h000;
      end else begin
         if (!busy) cwReg <= controlWord;
         sampCnt <= sampling ? sampCnt + 11'h001 : 11'h000;
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sampEnd;
      $fell(sampling);
   endsequence
   a_sample_len: assert property (sampEnd |-> sampCnt == sampLen)
      else $error("sample phase length wrong");
   a_sample_to_hold: assert property (sampEnd |-> holdSample && busy)
      else $error("no hold after sample phase");
   a_valid_pulse: assert property (resultValid |=> !resultValid)
      else $error("result pulse too long");
   a_load_end: assert property ($fell(holdSample) |-> resultValid && !busy)
      else $error("hold end without result load");
   a_busy_start: assert property ($rose(busy) |-> sampling)
      else $error("conversion not starting with sample");
   a_phase_excl: assert property (holdSample |-> !sampling && busy)
      else $error("hold and sample overlap");
   a_result_hold: assert property (!resultValid |-> $stable(result))
      else $error("result changed without load");
   a_cal_done: assert property (!calibrating |=> !calibrating)
      else $error("calibration restarted");
endmodule // adc_conversion_timing_checker

// >>> sim/test_adc_conversion_timing.sv
// self-checking bench for converter timing control
`timescale 1ns/1ps
module test_adc_conversion_timing;
   reg clk, rst_n, startConv, belowGround, aboveRef;
   reg [15:0] controlWord;
   reg [9:0] analogCode;
   wire busy, sampling, holdSample, calibrating, resultValid;
   wire [9:0] result;
   integer numErrors, totalChecks, cycles, busyLen, sampLen, i, t0, first;
   reg [10:0] d, n;
   adc_conversion_timing adc_conversion_timing_inst (.clk(clk), .rst_n(rst_n),
      .controlWord(controlWord), .startConv(startConv), .analogCode(analogCode),
      .belowGround(belowGround), .aboveRef(aboveRef), .busy(busy), .sampling(sampling),
      .holdSample(holdSample), .calibrating(calibrating), .resultValid(resultValid),
      .result(result));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, well above the roughly 62k cycles of the full run
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 80000) begin
         numErrors = numErrors + 1;
         wrapUp;
      end
   end
   // ----
   // tasks
   // ----
   task check(input [15:0] got, input [15:0] exp);
      begin
         totalChecks = totalChecks + 1;
         if (got !== exp) begin
            numErrors = numErrors + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task chkRange(input [15:0] got, input [15:0] lo, input [15:0] tol);
      check((got >= lo && got <= lo + tol) ? lo : got, lo);
   endtask
   function [10:0] divOf(input [1:0] s);
      divOf = (s == 2'h0) ? 11'h4 : (s == 2'h1) ? 11'h2 : (s == 2'h2) ? 11'h10 : 11'h8;
   endfunction
   task doReset;
      begin
         @(negedge clk);
         rst_n = 0;
         repeat (5) @(negedge clk);
         rst_n = 1;
      end
   endtask
   // input and settings disturbed in hold phase: result and length must not care
   task convert(input [15:0] cw, input [9:0] code, input bg, input ar, input [9:0] exp);
      begin
         controlWord = cw;
         analogCode = code;
         belowGround = bg;
         aboveRef = ar;
         startConv = 1;
         while (busy !== 1'b1) @(negedge clk);
         startConv = 0;
         busyLen = 0;
         sampLen = 0;
         while (resultValid !== 1'b1) begin
            if (busy === 1'b1) busyLen = busyLen + 1;
            if (sampling === 1'b1) sampLen = sampLen + 1;
            if (holdSample === 1'b1) begin
               analogCode = ~code;
               controlWord = ~cw;
            end
            @(negedge clk);
         end
         // settings back before idle latches them again
         controlWord = cw;
         analogCode = code;
         check({6'h0, result}, {6'h0, exp});
         @(negedge clk);
      end
   endtask
   task calTest(input withConv);
      begin
         controlWord = 16'hc000;
         doReset;
         t0 = cycles;
         busyLen = 0;
         if (withConv) convert(16'hc000, 10'h155, 0, 0, 10'h155);
         while (calibrating === 1'b1) @(negedge clk);
         chkRange(cycles - t0, 16'h6800 + busyLen[15:0], 8);
         $display("calibration test done, with conversion %0d", withConv);
      end
   endtask
   task wrapUp;
      begin
         $display("checks %0d mismatches %0d", totalChecks, numErrors);
         if (numErrors == 0 && totalChecks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      rst_n = 0;
      startConv = 0;
      belowGround = 0;
      aboveRef = 0;
      controlWord = 16'h0000;
      analogCode = 10'h000;
      numErrors = 0;
      totalChecks = 0;
      cycles = 0;
      calTest(0);
      calTest(1);
      // fast divider codes would push the basic clock past its limit at this cpu clock
      for (i = 8; i < 16; i = i + 1) begin
         d = divOf(i[3:2]);
         n = 11'h8 << i[1:0];
         convert({i[3:0], 12'h000}, 10'h2a5 ^ i[9:0], 0, 0, 10'h2a5 ^ i[9:0]);
         check(sampLen[15:0], {5'h0, n * d});
         check(busyLen[15:0], {5'h0, n * d + 11'h28 * d + 11'h2});
      end
      $display("clock and sample settings test done");
      convert(16'hc000, 10'h0f0, 0, 0, 10'h0f0);
      first = busyLen;
      convert(16'hc000, 10'h30f, 0, 0, 10'h30f);
      check(busyLen[15:0], first[15:0]);
      $display("repeat duration test done");
      convert(16'hd000, 10'h155, 1, 0, 10'h000);
      convert(16'hd000, 10'h155, 0, 1, 10'h3ff);
      convert(16'hd000, 10'h155, 1, 1, 10'h000);
      $display("rail test done");
      wrapUp;
   end
endmodule // test_adc_conversion_timing
bind adc_conversion_timing adc_conversion_timing_checker adc_conversion_timing_checker_inst (
   .clk(clk), .rst_n(rst_n), .controlWord(controlWord), .busy(busy), .sampling(sampling),
   .holdSample(holdSample), .calibrating(calibrating), .resultValid(resultValid),
   .result(result));
